// file: logic/fia_defines.svh
// fia_defines.svh: offsets, field positions, reset values and timing
// counts for the identity and station-address block.
// assumes: included by its bare name from the package and the design.
`ifndef FIA_DEFINES_SVH
`define FIA_DEFINES_SVH

// register offsets on the plain register port
`define FIA_OFS_IDSEL 8'h00
`define FIA_OFS_CTRL 8'h04
`define FIA_OFS_ADDR 8'h08
`define FIA_OFS_RESTORE 8'h0C
`define FIA_OFS_STATUS 8'h10
`define FIA_OFS_IDCODE 8'h14

// identity selector values
`define FIA_SEL_PROFILE 8'h00
`define FIA_SEL_NEW 8'h01
`define FIA_SEL_AUTO 8'h7F
`define FIA_SEL_OLD 8'h80

// control and status field positions
`define FIA_CTRL_STYLE_BIT 0
`define FIA_ST_ACT_LSB 0
`define FIA_ST_FIXED_BIT 2
`define FIA_ST_AUTO_BIT 3
`define FIA_ST_COND_BIT 4
`define FIA_ST_DIAGNEW_BIT 5
`define FIA_ST_CYCLIC_BIT 6
`define FIA_ST_SRC_BIT 7
`define FIA_ST_ADDR_LSB 8
`define FIA_ST_BLOCKS_LSB 16
`define FIA_ST_MODULES_LSB 20

// station address limits and defaults
`define FIA_ADDR_MAX 7'h7D
`define FIA_ADDR_FACTORY 7'h7E
`define FIA_RESTORE_CODE 32'h0000_0A98

// reset values
`define FIA_RST_IDSEL 8'h00
`define FIA_RST_STYLE 1'b0

// blocks and cyclic modules for profile and new identities
`define FIA_NEW_BLOCKS 4'h3
`define FIA_NEW_MODULES 4'h1

// switch settle time before restart
`define FIA_CLK_MHZ 125
`define FIA_SETTLE_S 10
`define FIA_SETTLE_CYC (`FIA_SETTLE_S * `FIA_CLK_MHZ * 1000000)

`endif

// file: logic/fia_pkg.sv
// fia_pkg.sv: types of the identity and station-address block.
// assumes: fia_defines.svh sits beside it.
`include "fia_defines.svh"

package fia_pkg;

    // identity in use
    typedef enum logic [1:0] {
        FIA_ID_PROFILE,
        FIA_ID_NEW,
        FIA_ID_OLD
    } fia_idx_t;

    // decoded master request frames, one-cycle strobes with their data
    typedef struct packed {
        logic set_prm;
        logic set_addr;
        logic get_diag;
        logic [15:0] ident;
        logic [6:0] addr;
        logic cond;
    } fia_frame_t;

    // identity view presented to the protocol engine
    typedef struct packed {
        logic [15:0] ident_code;
        logic condensed;
        logic diag_new;
        logic [3:0] blocks;
        logic [3:0] modules;
        logic [15:0] diag_code;
        logic diag_valid;
    } fia_ident_t;

    // whole block state
    typedef struct packed {
        logic [7:0] sel;
        logic style;
        logic cond_cfg;
        logic [6:0] sw_addr;
        logic [7:0] sw_lat;
        logic fixed;
        fia_idx_t act;
        fia_idx_t cand;
        logic start;
        logic [31:0] settle;
        logic [31:0] rdata;
        logic [15:0] diag_code;
        logic diag_valid;
    } fia_state_t;

endpackage

// file: logic/fia_ident_addr.sv
// fia_ident_addr.sv: identity selection and station address of a
// fieldbus slave port.
// assumes: single clock, synchronous inputs, frames decoded upstream.
//
// Function
// - selector 0 presents profile identity
// - selector 1 presents new-generation identity
// - selector 128: old identity, classic, old diag
// - selector 127 enters adaptation mode
// - selector change ignored during cyclic exchange
// - identity kept across cyclic run
// - blocks and modules follow identity
// - adaptation fixes identity from known request
// - unfixed adaptation rotates identity per diagnose
// - master switches identity only in adaptation
// - status style from config or parameter
// - software station addresses lie in 0 to 125
// - factory address 126, software addressing
// - switch 8 selects address source
// - hardware address is weighted switch sum
// - switch change restarts within ten seconds
// - menu refuses 126; code restores 126
// - report stored address after restart
`timescale 1ns/1ps
`default_nettype none
`include "fia_defines.svh"

module fia_ident_addr
    import fia_pkg::*;
#(
    parameter logic [15:0] ID_PROFILE = 16'h0A01, // arbitrary value
    parameter logic [15:0] ID_NEW = 16'h0A02, // arbitrary value
    parameter logic [15:0] ID_OLD = 16'h0A03, // arbitrary value
    parameter logic [3:0] OLD_BLOCKS = 4'h3,
    parameter logic [3:0] OLD_MODULES = 4'h1,
    parameter logic [31:0] SETTLE_CYC = 32'(`FIA_SETTLE_CYC)
)
(
    // clock and reset
    input wire logic core_clk,
    input wire logic sys_rst,
    // register port
    input wire logic [7:0] reg_addr,
    input wire logic [31:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [31:0] reg_rdata,
    // switches: [6:0] weights, [7] address_source_switch
    input wire logic [7:0] addr_switch,
    // link state and decoded frames
    input wire logic cyclic_active,
    input wire fia_frame_t frame,
    // identity and address presented to the protocol engine
    output fia_ident_t ident,
    output logic [6:0] station_addr,
    output logic restart
);

    fia_state_t s_q;
    fia_state_t s_d;
    logic auto_mode;
    logic cond_w;
    logic [6:0] hw_addr;
    logic settle_done;

    // code of an identity
    function automatic logic [15:0] code_of(input fia_idx_t i);
        case (i)
            FIA_ID_PROFILE: code_of = ID_PROFILE;
            FIA_ID_NEW: code_of = ID_NEW;
            default: code_of = ID_OLD;
        endcase
    endfunction

    // identity of a known code
    function automatic fia_idx_t idx_of(input logic [15:0] c);
        if (c == ID_NEW)
        begin
            idx_of = FIA_ID_NEW;
        end
        else if (c == ID_OLD)
        begin
            idx_of = FIA_ID_OLD;
        end
        else
        begin
            idx_of = FIA_ID_PROFILE;
        end
    endfunction

    // next candidate offered in adaptation
    function automatic fia_idx_t next_of(input fia_idx_t i);
        case (i)
            FIA_ID_PROFILE: next_of = FIA_ID_NEW;
            FIA_ID_NEW: next_of = FIA_ID_OLD;
            default: next_of = FIA_ID_PROFILE;
        endcase
    endfunction

    // --------------------------------------------------------------
    // derived views
    // --------------------------------------------------------------

    // adaptation mode and status style
    assign auto_mode = (s_q.sel == `FIA_SEL_AUTO);
    assign cond_w = (s_q.act != FIA_ID_OLD) &&
        (s_q.style || s_q.cond_cfg);
    // weighted switch sum, latched only at restart
    assign hw_addr = s_q.sw_lat[6:0];
    assign settle_done = (s_q.settle >= SETTLE_CYC - 32'h0000_0001);

    // outputs
    always_comb
    begin
        ident.ident_code = code_of(s_q.act);
        ident.condensed = cond_w;
        ident.diag_new = (s_q.act != FIA_ID_OLD);
        ident.blocks = (s_q.act == FIA_ID_OLD) ? OLD_BLOCKS
            : `FIA_NEW_BLOCKS;
        ident.modules = (s_q.act == FIA_ID_OLD) ? OLD_MODULES
            : `FIA_NEW_MODULES;
        ident.diag_code = s_q.diag_code;
        ident.diag_valid = s_q.diag_valid;
        station_addr = s_q.sw_lat[7] ? s_q.sw_addr : hw_addr;
        restart = s_q.start;
        reg_rdata = s_q.rdata;
    end

    // --------------------------------------------------------------
    // next state
    // --------------------------------------------------------------

    // register port, frames, adaptation and restart
    always_comb
    begin
        s_d = s_q;
        s_d.diag_valid = 1'b0;
        s_d.rdata = 32'h0000_0000;
        s_d.start = 1'b0;
        // restart: sample switches, forget the adapted identity
        if (s_q.start)
        begin
            s_d.sw_lat = addr_switch;
            s_d.settle = 32'h0000_0000;
            s_d.fixed = 1'b0;
            s_d.cand = FIA_ID_PROFILE;
            if (auto_mode)
            begin
                s_d.act = FIA_ID_PROFILE;
            end
        end
        else if (addr_switch != s_q.sw_lat)
        begin
            // count settle time, then restart on the new address
            if (settle_done)
            begin
                s_d.start = 1'b1;
            end
            else
            begin
                s_d.settle = s_q.settle + 32'h0000_0001;
            end
        end
        else
        begin
            s_d.settle = 32'h0000_0000;
        end
        // register writes
        if (reg_wr)
        begin
            case (reg_addr)
                `FIA_OFS_IDSEL:
                begin
                    // ignored while cyclic exchange runs
                    if (!cyclic_active)
                    begin
                        s_d.fixed = 1'b0;
                        s_d.cand = FIA_ID_PROFILE;
                        case (reg_wdata[7:0])
                            `FIA_SEL_PROFILE:
                            begin
                                s_d.sel = reg_wdata[7:0];
                                s_d.act = FIA_ID_PROFILE;
                            end
                            `FIA_SEL_NEW:
                            begin
                                s_d.sel = reg_wdata[7:0];
                                s_d.act = FIA_ID_NEW;
                            end
                            `FIA_SEL_OLD:
                            begin
                                s_d.sel = reg_wdata[7:0];
                                s_d.act = FIA_ID_OLD;
                            end
                            `FIA_SEL_AUTO:
                            begin
                                s_d.sel = reg_wdata[7:0];
                                s_d.act = FIA_ID_PROFILE;
                            end
                            default:
                            begin
                                s_d.fixed = s_q.fixed;
                                s_d.cand = s_q.cand;
                            end
                        endcase
                    end
                end
                `FIA_OFS_CTRL:
                begin
                    s_d.style = reg_wdata[`FIA_CTRL_STYLE_BIT];
                end
                `FIA_OFS_ADDR:
                begin
                    // menu entry: factory address and out of range refused
                    if (reg_wdata[31:0] <= 32'(`FIA_ADDR_MAX))
                    begin
                        s_d.sw_addr = reg_wdata[6:0];
                    end
                end
                `FIA_OFS_RESTORE:
                begin
                    if (reg_wdata == `FIA_RESTORE_CODE)
                    begin
                        s_d.sw_addr = `FIA_ADDR_FACTORY;
                    end
                end
                default:
                begin
                end
            endcase
        end
        // register reads, data one cycle later
        if (reg_rd)
        begin
            case (reg_addr)
                `FIA_OFS_IDSEL: s_d.rdata = {24'h00_0000, s_q.sel};
                `FIA_OFS_CTRL: s_d.rdata = {31'h0000_0000, s_q.style};
                `FIA_OFS_ADDR: s_d.rdata = {25'h000_0000, s_q.sw_addr};
                `FIA_OFS_STATUS:
                begin
                    s_d.rdata[`FIA_ST_ACT_LSB +: 2] = s_q.act;
                    s_d.rdata[`FIA_ST_FIXED_BIT] = s_q.fixed;
                    s_d.rdata[`FIA_ST_AUTO_BIT] = auto_mode;
                    s_d.rdata[`FIA_ST_COND_BIT] = cond_w;
                    s_d.rdata[`FIA_ST_DIAGNEW_BIT] = ident.diag_new;
                    s_d.rdata[`FIA_ST_CYCLIC_BIT] = cyclic_active;
                    s_d.rdata[`FIA_ST_SRC_BIT] = s_q.sw_lat[7];
                    s_d.rdata[`FIA_ST_ADDR_LSB +: 7] = station_addr;
                    s_d.rdata[`FIA_ST_BLOCKS_LSB +: 4] = ident.blocks;
                    s_d.rdata[`FIA_ST_MODULES_LSB +: 4] = ident.modules;
                end
                `FIA_OFS_IDCODE: s_d.rdata = {16'h0000, ident.ident_code};
                default: s_d.rdata = 32'h0000_0000;
            endcase
        end
        // diagnose request: answer, rotating while unfixed in adaptation
        if (frame.get_diag)
        begin
            s_d.diag_valid = 1'b1;
            if (auto_mode && !s_q.fixed)
            begin
                s_d.diag_code = code_of(s_q.cand);
                s_d.act = s_q.cand;
                s_d.cand = next_of(s_q.cand);
            end
            else
            begin
                s_d.diag_code = code_of(s_q.act);
            end
        end
        // parameter or address request fixes a known identity
        if ((frame.set_prm || frame.set_addr) && auto_mode &&
            !s_q.fixed && !cyclic_active &&
            (frame.ident == ID_PROFILE || frame.ident == ID_NEW ||
             frame.ident == ID_OLD))
        begin
            s_d.act = idx_of(frame.ident);
            s_d.fixed = 1'b1;
        end
        // status style taken from the master's configuration
        if (frame.set_prm)
        begin
            s_d.cond_cfg = frame.cond;
        end
        // station address set by the master, software addressing only
        if (frame.set_addr && s_q.sw_lat[7] && !cyclic_active &&
            frame.addr <= `FIA_ADDR_MAX)
        begin
            s_d.sw_addr = frame.addr;
        end
    end

    // --------------------------------------------------------------
    // state register
    // --------------------------------------------------------------

    // factory state on reset, restart on the first edge after it
    always_ff @(posedge core_clk)
    begin
        if (sys_rst)
        begin
            s_q.sel <= `FIA_RST_IDSEL;
            s_q.style <= `FIA_RST_STYLE;
            s_q.cond_cfg <= 1'b0;
            s_q.sw_addr <= `FIA_ADDR_FACTORY;
            s_q.sw_lat <= 8'h80;
            s_q.fixed <= 1'b0;
            s_q.act <= FIA_ID_PROFILE;
            s_q.cand <= FIA_ID_PROFILE;
            s_q.start <= 1'b1;
            s_q.settle <= 32'h0000_0000;
            s_q.rdata <= 32'h0000_0000;
            s_q.diag_code <= 16'h0000;
            s_q.diag_valid <= 1'b0;
        end
        else
        begin
            s_q <= s_d;
        end
    end

    // --------------------------------------------------------------
    // assertions
    // --------------------------------------------------------------

    default clocking cb @(posedge core_clk);
    endclocking
    default disable iff (sys_rst);

    AST_SEL_PROFILE: assert property (
        s_q.sel == `FIA_SEL_PROFILE |-> ident.ident_code == ID_PROFILE)
        else $error("profile selector without profile identity");

    AST_SEL_NEW: assert property (
        s_q.sel == `FIA_SEL_NEW |-> ident.ident_code == ID_NEW)
        else $error("new selector without new identity");

    AST_SEL_OLD: assert property (
        s_q.sel == `FIA_SEL_OLD |-> !ident.condensed && !ident.diag_new)
        else $error("old identity not classic");

    AST_CYCLIC_HOLD: assert property (
        cyclic_active && reg_wr && reg_addr == `FIA_OFS_IDSEL
        |=> $stable(s_q.sel))
        else $error("selector changed during cyclic exchange");

    AST_IDENT_KEPT: assert property (
        cyclic_active && !s_q.start && !(frame.get_diag && auto_mode &&
        !s_q.fixed) |=> $stable(s_q.act))
        else $error("identity changed during cyclic exchange");

    AST_MODULES: assert property (
        s_q.act != FIA_ID_OLD |-> ident.blocks == 4'h3 &&
        ident.modules == 4'h1)
        else $error("wrong block or module count");

    AST_FIX: assert property (
        frame.set_prm && auto_mode && !s_q.fixed && !cyclic_active &&
        frame.ident == ID_NEW && !reg_wr |=> s_q.fixed && s_q.act == FIA_ID_NEW)
        else $error("adaptation did not fix identity");

    AST_ROTATE: assert property (
        frame.get_diag && auto_mode && !s_q.fixed && !reg_wr &&
        !frame.set_prm && !frame.set_addr && !s_q.start
        |=> ident.diag_valid && s_q.cand != $past(s_q.cand) &&
        ident.diag_code == code_of($past(s_q.cand)))
        else $error("diagnose answer did not rotate");

    AST_ADDR_RANGE: assert property (
        s_q.sw_lat[7] |-> station_addr <= 7'h7D || s_q.sw_addr == 7'h7E)
        else $error("station address out of range");

    AST_RESTORE: assert property (
        reg_wr && reg_addr == `FIA_OFS_RESTORE &&
        reg_wdata == `FIA_RESTORE_CODE && !frame.set_addr
        |=> s_q.sw_addr == 7'h7E)
        else $error("restore code did not give factory address");

    AST_HW_ADDR: assert property (
        s_q.start ##1 !s_q.sw_lat[7] |-> station_addr == $past(addr_switch[6:0]))
        else $error("hardware address not the switch sum");

    AST_READ_LAT: assert property (
        reg_rd && reg_addr == `FIA_OFS_ADDR
        |=> reg_rdata == {25'h000_0000, $past(s_q.sw_addr)})
        else $error("address read back wrong");

endmodule
`default_nettype wire

// file: testbench/fia_master_model.sv
// fia_master_model.sv: behavioural class 1 and class 2 masters that
// send decoded request frames and hold the cyclic exchange level.
// assumes: the bench calls its tasks one at a time, never overlapping.
`timescale 1ns/1ps
`default_nettype none

module fia_master_model
    import fia_pkg::*;
(
    // clock
    input wire logic core_clk,
    // frames and link state
    output var fia_frame_t frame,
    output var logic cyclic_active
);
    // ------------------------------------------------------------
    // request frames
    // ------------------------------------------------------------

    // idle at time zero
    initial
    begin
        frame = '0;
        cyclic_active = 1'b0;
    end

    // one-cycle pulse; kind bit 0 set_prm, 1 set_addr, 2 get_diag
    task automatic send(input logic [2:0] kind, input logic [15:0] id,
                        input logic [6:0] ad, input logic cd);
    begin
        @(posedge core_clk);
        frame.set_prm <= kind[0];
        frame.set_addr <= kind[1];
        frame.get_diag <= kind[2];
        frame.ident <= id;
        frame.addr <= ad;
        frame.cond <= cd;
        @(posedge core_clk);
        // released data never keeps its last value
        frame.set_prm <= 1'b0;
        frame.set_addr <= 1'b0;
        frame.get_diag <= 1'b0;
        frame.ident <= ~id;
        frame.addr <= ~ad;
        frame.cond <= ~cd;
        #1;
    end
    endtask

    // class 1 master starts or stops cyclic exchange
    task automatic cyc(input logic on);
    begin
        @(posedge core_clk);
        cyclic_active <= on;
        // let the new level settle so a following test of it sees it
        #1;
    end
    endtask

    // class 2 master ends its connection before setting the address
    task automatic saddr(input logic [6:0] ad);
    begin
        if (cyclic_active)
            cyc(1'b0);
        send(3'h2, 16'h0000, ad, 1'b0);
    end
    endtask
endmodule

`default_nettype wire

// file: testbench/test_fia_ident_addr.sv
// test_fia_ident_addr.sv: self-checking bench for the identity and
// station-address block, with a master model on the frame side.
// assumes: fia_pkg and fia_defines.svh compiled first.
`timescale 1ns/1ps
`default_nettype none
`include "fia_defines.svh"

module test_fia_ident_addr;
    import fia_pkg::*;

    // ------------------------------------------------------------
    // signals and design
    // ------------------------------------------------------------
    localparam logic [15:0] P_ID = 16'h0A01; // arbitrary value
    localparam logic [15:0] N_ID = 16'h0A02; // arbitrary value
    localparam logic [15:0] O_ID = 16'h0A03; // arbitrary value
    logic core_clk = 1'b0;
    logic sys_rst = 1'b1;
    logic [7:0] reg_addr = 8'h00;
    logic [31:0] reg_wdata = 32'h0;
    logic reg_wr = 1'b0;
    logic reg_rd = 1'b0;
    logic [31:0] reg_rdata;
    logic [7:0] addr_switch = 8'h80;
    logic cyclic_active;
    fia_frame_t frame;
    fia_ident_t ident;
    logic [6:0] station_addr;
    logic restart;
    int failures = 0;
    int n_checks = 0;
    logic [31:0] rv;
    logic [15:0] exp_id [4] = '{P_ID, N_ID, O_ID, P_ID};
    logic [7:0] sel_v [3] = '{8'h00, 8'h01, 8'h80};
    logic [7:0] bm_v [3] = '{8'h31, 8'h31, 8'h22};

    // 125 MHz clock
    always #4 core_clk = ~core_clk;

    // identity codes keep their defaults; the bench mirrors them above
    fia_ident_addr #(
        .OLD_BLOCKS(4'h2),
        .OLD_MODULES(4'h2),
        .SETTLE_CYC(32'h14)
    ) u_dut (
        .core_clk(core_clk),
        .sys_rst(sys_rst),
        .reg_addr(reg_addr),
        .reg_wdata(reg_wdata),
        .reg_wr(reg_wr),
        .reg_rd(reg_rd),
        .reg_rdata(reg_rdata),
        .addr_switch(addr_switch),
        .cyclic_active(cyclic_active),
        .frame(frame),
        .ident(ident),
        .station_addr(station_addr),
        .restart(restart)
    );

    fia_master_model u_master (
        .core_clk(core_clk),
        .frame(frame),
        .cyclic_active(cyclic_active)
    );

    // ------------------------------------------------------------
    // tasks
    // ------------------------------------------------------------

    // compare and count
    task automatic chk(input string what, input logic [31:0] exp,
                       input logic [31:0] got);
    begin
        n_checks++;
        if (got !== exp)
        begin
            failures++;
            $display("[FAIL] %s expected %h seen %h", what, exp, got);
        end
    end
    endtask

    // verdict and end of run
    task automatic conclude();
    begin
        $display("checks %0d failures %0d", n_checks, failures);
        if (failures == 0 && n_checks > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    end
    endtask

    // settle just after the next rising edge
    task automatic tick();
    begin
        @(posedge core_clk);
        #1;
    end
    endtask

    // one-cycle register write
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
    begin
        @(posedge core_clk);
        reg_wr <= 1'b1;
        reg_addr <= a;
        reg_wdata <= d;
        @(posedge core_clk);
        reg_wr <= 1'b0;
        #1;
    end
    endtask

    // one-cycle register read, data taken in the following cycle
    task automatic rd(input logic [7:0] a, output logic [31:0] d);
    begin
        @(posedge core_clk);
        reg_rd <= 1'b1;
        reg_addr <= a;
        @(posedge core_clk);
        reg_rd <= 1'b0;
        #1;
        d = reg_rdata;
    end
    endtask

    // bounded wait for the restart pulse, then one edge to latch
    task automatic wait_restart();
        int i;
    begin
        for (i = 0; i < 200 && restart !== 1'b1; i++)
            tick();
        if (restart !== 1'b1)
        begin
            failures++;
            $display("[FAIL] restart expected 1 seen %b", restart);
            conclude();
        end
        tick();
    end
    endtask

    // ------------------------------------------------------------
    // main sequence
    // ------------------------------------------------------------
    initial
    begin
        repeat (16) @(posedge core_clk);
        sys_rst <= 1'b0;
        repeat (3) tick();
        // factory state, software addressing
        rd(`FIA_OFS_ADDR, rv);
        chk("addr_reg", 32'h7E, rv);
        chk("station", 32'h7E, {25'h0, station_addr});
        chk("ident", {16'h0, P_ID}, {16'h0, ident.ident_code});
        rd(8'h30, rv);
        chk("unmapped", 32'h0, rv);
        // fixed selectors with the stored style set to condensed
        wr(`FIA_OFS_CTRL, 32'h1);
        for (int k = 0; k < 3; k++)
        begin
            wr(`FIA_OFS_IDSEL, {24'h0, sel_v[k]});
            chk("ident", {16'h0, exp_id[k]}, {16'h0, ident.ident_code});
            chk("cond", {31'h0, k != 2}, {31'h0, ident.condensed});
            chk("diagnew", {31'h0, k != 2}, {31'h0, ident.diag_new});
            chk("blk_mod", {24'h0, bm_v[k]}, {24'h0, ident.blocks, ident.modules});
        end
        wr(`FIA_OFS_IDSEL, 32'h5);
        chk("bad_sel", {16'h0, O_ID}, {16'h0, ident.ident_code});
        // classic by parameter, condensed by master configuration
        wr(`FIA_OFS_CTRL, 32'h0);
        wr(`FIA_OFS_IDSEL, 32'h1);
        chk("cond", 32'h0, {31'h0, ident.condensed});
        u_master.send(3'h1, O_ID, 7'h00, 1'b1);
        chk("cond", 32'h1, {31'h0, ident.condensed});
        chk("ident", {16'h0, N_ID}, {16'h0, ident.ident_code});
        u_master.send(3'h1, N_ID, 7'h00, 1'b0);
        // selector frozen while cyclic exchange runs
        u_master.cyc(1'b1);
        wr(`FIA_OFS_IDSEL, 32'h80);
        rd(`FIA_OFS_IDSEL, rv);
        chk("sel_cyc", 32'h1, rv);
        u_master.cyc(1'b0);
        tick();
        chk("ident", {16'h0, N_ID}, {16'h0, ident.ident_code});
        // adaptation mode: rotation, unknown code, then fixing
        wr(`FIA_OFS_IDSEL, 32'h7F);
        rd(`FIA_OFS_STATUS, rv);
        chk("auto", 32'h1, {31'h0, rv[`FIA_ST_AUTO_BIT]});
        for (int k = 0; k < 4; k++)
        begin
            u_master.send(3'h4, 16'h0000, 7'h00, 1'b0);
            chk("dvalid", 32'h1, {31'h0, ident.diag_valid});
            chk("dcode", {16'h0, exp_id[k]}, {16'h0, ident.diag_code});
            chk("ident", {16'h0, exp_id[k]}, {16'h0, ident.ident_code});
        end
        tick();
        chk("dvalid", 32'h0, {31'h0, ident.diag_valid});
        u_master.send(3'h1, 16'h0C7F, 7'h00, 1'b0);
        chk("unknown", {16'h0, P_ID}, {16'h0, ident.ident_code});
        u_master.send(3'h1, O_ID, 7'h00, 1'b0);
        chk("fixed", {16'h0, O_ID}, {16'h0, ident.ident_code});
        chk("diagnew", 32'h0, {31'h0, ident.diag_new});
        u_master.send(3'h4, 16'h0000, 7'h00, 1'b0);
        chk("ident", {16'h0, O_ID}, {16'h0, ident.ident_code});
        // software address by register, restore code and frame
        wr(`FIA_OFS_ADDR, 32'h7D);
        chk("station", 32'h7D, {25'h0, station_addr});
        wr(`FIA_OFS_ADDR, 32'h7E);
        rd(`FIA_OFS_ADDR, rv);
        chk("addr_126", 32'h7D, rv);
        wr(`FIA_OFS_RESTORE, 32'hA97);
        rd(`FIA_OFS_ADDR, rv);
        chk("bad_code", 32'h7D, rv);
        wr(`FIA_OFS_RESTORE, `FIA_RESTORE_CODE);
        rd(`FIA_OFS_ADDR, rv);
        chk("restore", 32'h7E, rv);
        u_master.cyc(1'b1);
        u_master.saddr(7'h05);
        chk("station", 32'h05, {25'h0, station_addr});
        u_master.saddr(7'h7F);
        rd(`FIA_OFS_ADDR, rv);
        chk("addr_127", 32'h05, rv);
        // hardware address from weighted switches
        @(posedge core_clk);
        addr_switch <= 8'h55;
        wait_restart();
        chk("hw_addr", 32'h55, {25'h0, station_addr});
        @(posedge core_clk);
        addr_switch <= 8'h2A;
        repeat (5) tick();
        chk("no_sample", 32'h55, {25'h0, station_addr});
        @(posedge core_clk);
        addr_switch <= 8'h80;
        wait_restart();
        chk("sw_addr", 32'h05, {25'h0, station_addr});
        conclude();
    end
endmodule

`default_nettype wire
